//--- hw/dmtc_top.sv
// Purpose: dual mode timer/counter with two channels behind an APB slave
// Assumes: pins are asynchronous; overflow acknowledges come from the
//   interrupt controller on CLK_IN as one-cycle pulses
// Notes: zero wait state bus; unmapped addresses answer with PSLVERR
//
// Behaviour
// RL1: timer operation increments once per peripheral cycle of six clocks.
// RL2: source select picks divided clock (0) or count pin (1).
// RL3: count pin sampled each peripheral cycle; high then low counts once.
// RL4: outside source holds each count pin level one full peripheral cycle.
// RL5: setting run bit keeps count bytes as starting value.
// RL6: software stops the channel before presetting count bytes.
// RL7: software stops the channel before changing mode or source.
// RL8: first channel uses mode nibble low and control bits 4,5.
// RL9: gate off means run bit alone; gate on adds gate pin.
// RL10: rollover from all ones to zero sets overflow flag, raising interrupt.
// RL11: overflow flag clears when the processor services its interrupt.
// RL12: mode 0 is 5-bit prescaler in low byte feeding high byte.
// RL13: mode 1 cascades low and high bytes into sixteen bits.
// RL14: mode 2 reloads low byte from high byte on overflow.
// RL15: mode 2 high byte writable anytime, used at next reload.
// RL16: mode 3 low byte is an 8-bit timer with first controls.
// RL17: mode 3 high byte counts divided clock, second run bit and flag.
// RL18: second channel matches first but halts and holds in mode 3.
// RL19: mode field codes 00,01,10,11 for modes 0 to 3.
// RL20: with gating, count only while gate pin high and run set.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dmtc_top (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [dmtc_pkg::APB_AW-1:0] PADDR_IN,
  input wire logic [dmtc_pkg::APB_DW-1:0] PWDATA_IN,
  output logic [dmtc_pkg::APB_DW-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic FIRST_COUNT_PIN_IN,
  input wire logic SECOND_COUNT_PIN_IN,
  input wire logic FIRST_EXTERNAL_GATE_PIN_IN,
  input wire logic SECOND_EXTERNAL_GATE_PIN_IN,
  input wire logic FIRST_IRQ_ACK_IN,
  input wire logic SECOND_IRQ_ACK_IN,
  output logic FIRST_IRQ_OUT,
  output logic SECOND_IRQ_OUT
);

  function automatic logic addr_hit(input logic [dmtc_pkg::APB_AW-1:0] addr,
                                    input logic [dmtc_pkg::APB_AW-1:0] offset);
    addr_hit = (addr == offset);
  endfunction

  // pin synchronisers: the third stage guards against a single-sample glitch
  logic [dmtc_pkg::PIN_N-1:0] pin_meta_reg;
  logic [dmtc_pkg::PIN_N-1:0] pin_sync_reg;
  logic [dmtc_pkg::PIN_N-1:0] pin_late_reg;
  logic [dmtc_pkg::PIN_N-1:0] pin_level_reg;
  logic [dmtc_pkg::PIN_N-1:0] pin_level_next;
  wire logic [dmtc_pkg::PIN_N-1:0] pin_raw = {SECOND_EXTERNAL_GATE_PIN_IN,
    FIRST_EXTERNAL_GATE_PIN_IN, SECOND_COUNT_PIN_IN, FIRST_COUNT_PIN_IN};

  always_comb
  begin
    for (int i = 0; i < dmtc_pkg::PIN_N; i++)
    begin
      pin_level_next[i] = (pin_sync_reg[i] == pin_late_reg[i]) ? pin_late_reg[i]
                                                               : pin_level_reg[i];
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_late_reg <= '0;
      pin_level_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_late_reg <= pin_sync_reg;
      pin_level_reg <= pin_level_next;
    end
  end

  // RL1 peripheral cycle
  logic [dmtc_pkg::DIV_W-1:0] div_reg;
  wire logic tick = (div_reg == dmtc_pkg::DIV_LAST);
  wire logic [dmtc_pkg::DIV_W-1:0] div_next = tick ? dmtc_pkg::DIV_ZERO
                                                   : div_reg + dmtc_pkg::DIV_ONE;

  // RL3 falling edge sampling
  logic [1:0] count_sample_reg;
  wire logic [1:0] count_now = {pin_level_reg[dmtc_pkg::PIN_COUNT1],
                                pin_level_reg[dmtc_pkg::PIN_COUNT0]};
  wire logic [1:0] count_fall = {2{tick}} & count_sample_reg & ~count_now;

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      div_reg <= dmtc_pkg::DIV_ZERO;
      count_sample_reg <= '0;
    end
    else
    begin
      div_reg <= div_next;
      if (tick)
      begin
        count_sample_reg <= count_now;
      end
    end
  end

  // bus decode
  wire logic setup_phase = PSEL_IN && !PENABLE_IN;
  wire logic access_phase = PSEL_IN && PENABLE_IN;
  wire logic wr_access = access_phase && PWRITE_IN;
  wire logic hit_mode = addr_hit(PADDR_IN, dmtc_pkg::OFF_MODE);
  wire logic hit_ctrl = addr_hit(PADDR_IN, dmtc_pkg::OFF_CTRL);
  wire logic hit_low0 = addr_hit(PADDR_IN, dmtc_pkg::OFF_LOW0);
  wire logic hit_high0 = addr_hit(PADDR_IN, dmtc_pkg::OFF_HIGH0);
  wire logic hit_low1 = addr_hit(PADDR_IN, dmtc_pkg::OFF_LOW1);
  wire logic hit_high1 = addr_hit(PADDR_IN, dmtc_pkg::OFF_HIGH1);
  wire logic hit_any = hit_mode || hit_ctrl || hit_low0 || hit_high0 || hit_low1 || hit_high1;
  wire logic [dmtc_pkg::BYTE_W-1:0] wbyte = PWDATA_IN[dmtc_pkg::BYTE_W-1:0];

  // software-visible control state
  logic [dmtc_pkg::BYTE_W-1:0] timer_mode_register_reg;
  logic [dmtc_pkg::BYTE_W-1:0] timer_control_register_reg;
  logic [dmtc_pkg::BYTE_W-1:0] timer_control_register_next;
  logic [dmtc_pkg::APB_DW-1:0] rdata_reg;

  // RL8 RL19 control layout
  wire dmtc_pkg::dmtc_chcfg_s first_cfg =
    timer_mode_register_reg[dmtc_pkg::CFG0_LSB +: dmtc_pkg::CFG_W];
  wire dmtc_pkg::dmtc_chcfg_s second_cfg =
    timer_mode_register_reg[dmtc_pkg::CFG1_LSB +: dmtc_pkg::CFG_W];
  wire logic first_run_bit = timer_control_register_reg[dmtc_pkg::CTRL_RUN0_BIT];
  wire logic second_run_bit = timer_control_register_reg[dmtc_pkg::CTRL_RUN1_BIT];
  wire logic first_overflow_flag = timer_control_register_reg[dmtc_pkg::CTRL_FLAG0_BIT];
  wire logic second_overflow_flag = timer_control_register_reg[dmtc_pkg::CTRL_FLAG1_BIT];

  logic [dmtc_pkg::BYTE_W-1:0] first_count_low;
  logic [dmtc_pkg::BYTE_W-1:0] first_count_high;
  logic [dmtc_pkg::BYTE_W-1:0] second_count_low;
  logic [dmtc_pkg::BYTE_W-1:0] second_count_high;
  logic first_low_ovf;
  logic first_high_ovf;
  logic second_low_ovf;

  // RL16 RL17 first channel
  dmtc_channel #(
    .HALT_IN_SPLIT(1'b0)
  ) u_first (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .cfg_in(first_cfg),
    .run_in(first_run_bit),
    .gate_pin_in(pin_level_reg[dmtc_pkg::PIN_FIRST_GATE_ENABLE]),
    .tick_in(tick),
    .fall_in(count_fall[0]),
    .high_run_in(second_run_bit),
    .wr_low_in(wr_access && hit_low0),
    .wr_high_in(wr_access && hit_high0),
    .wdata_in(wbyte),
    .low_out(first_count_low),
    .high_out(first_count_high),
    .low_ovf_out(first_low_ovf),
    .high_ovf_out(first_high_ovf)
  );

  // RL18 second channel halts
  dmtc_channel #(
    .HALT_IN_SPLIT(1'b1)
  ) u_second (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .cfg_in(second_cfg),
    .run_in(second_run_bit),
    .gate_pin_in(pin_level_reg[dmtc_pkg::PIN_GATE1]),
    .tick_in(tick),
    .fall_in(count_fall[1]),
    .high_run_in(1'b0),
    .wr_low_in(wr_access && hit_low1),
    .wr_high_in(wr_access && hit_high1),
    .wdata_in(wbyte),
    .low_out(second_count_low),
    .high_out(second_count_high),
    .low_ovf_out(second_low_ovf),
    .high_ovf_out()
  );

  // RL10 RL17 flag sources
  wire logic first_flag_set = first_low_ovf;
  wire logic second_flag_set = second_low_ovf || first_high_ovf;

  // RL11 service clears flag, a set in the same cycle wins
  always_comb
  begin
    timer_control_register_next = timer_control_register_reg;
    if (wr_access && hit_ctrl)
    begin
      timer_control_register_next = wbyte;
    end
    timer_control_register_next[dmtc_pkg::CTRL_FLAG0_BIT] = first_flag_set ||
      (timer_control_register_next[dmtc_pkg::CTRL_FLAG0_BIT] && !FIRST_IRQ_ACK_IN);
    timer_control_register_next[dmtc_pkg::CTRL_FLAG1_BIT] = second_flag_set ||
      (timer_control_register_next[dmtc_pkg::CTRL_FLAG1_BIT] && !SECOND_IRQ_ACK_IN);
  end

  // read data captured in setup so it stands through the access phase
  wire logic [dmtc_pkg::BYTE_W-1:0] rbyte =
    hit_mode ? timer_mode_register_reg :
    hit_ctrl ? timer_control_register_reg :
    hit_low0 ? first_count_low :
    hit_high0 ? first_count_high :
    hit_low1 ? second_count_low :
    hit_high1 ? second_count_high : dmtc_pkg::COUNT_RST;

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      timer_mode_register_reg <= dmtc_pkg::MODE_RST;
      timer_control_register_reg <= dmtc_pkg::CTRL_RST;
      rdata_reg <= '0;
    end
    else
    begin
      // RL7 mode writes
      if (wr_access && hit_mode)
      begin
        timer_mode_register_reg <= wbyte;
      end
      timer_control_register_reg <= timer_control_register_next;
      if (setup_phase)
      begin
        rdata_reg <= {{(dmtc_pkg::APB_DW - dmtc_pkg::BYTE_W){1'b0}}, rbyte};
      end
    end
  end

  assign PRDATA_OUT = rdata_reg;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access_phase && !hit_any;
  assign FIRST_IRQ_OUT = first_overflow_flag;
  assign SECOND_IRQ_OUT = second_overflow_flag;

endmodule

//--- hw/dmtc_pkg.sv
// Purpose: shared constants and types of the dual mode timer/counter
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: registers hold 8 bits in the low lane, upper bits read as zero
package dmtc_pkg;

  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int BYTE_W = 8;

  // register byte offsets
  localparam logic [APB_AW-1:0] OFF_MODE = 8'h00;
  localparam logic [APB_AW-1:0] OFF_CTRL = 8'h04;
  localparam logic [APB_AW-1:0] OFF_LOW0 = 8'h08;
  localparam logic [APB_AW-1:0] OFF_HIGH0 = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_LOW1 = 8'h10;
  localparam logic [APB_AW-1:0] OFF_HIGH1 = 8'h14;

  // reset values
  localparam logic [BYTE_W-1:0] MODE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;
  localparam logic [BYTE_W-1:0] COUNT_RST = 8'h00;

  // field layout of the timer mode register: one nibble per channel
  localparam int CFG_W = 4;
  localparam int CFG0_LSB = 0;
  localparam int CFG1_LSB = 4;

  // field layout of the timer control register
  localparam int CTRL_LEVEL0_BIT = 0;
  localparam int CTRL_EDGE0_BIT = 1;
  localparam int CTRL_LEVEL1_BIT = 2;
  localparam int CTRL_EDGE1_BIT = 3;
  localparam int CTRL_RUN0_BIT = 4;
  localparam int CTRL_FLAG0_BIT = 5;
  localparam int CTRL_RUN1_BIT = 6;
  localparam int CTRL_FLAG1_BIT = 7;

  // one peripheral cycle is this many clock periods
  localparam int PER_CLK_DIV = 6;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'(PER_CLK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;

  localparam int PRESCALE_W = 5;
  localparam logic [PRESCALE_W-1:0] PRESCALE_MAX = 5'h1F;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 5'h01;
  localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hFF;
  localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;

  // external pins: two count inputs and two gate inputs
  localparam int PIN_N = 4;
  localparam int PIN_COUNT0 = 0;
  localparam int PIN_COUNT1 = 1;
  localparam int PIN_FIRST_GATE_ENABLE = 2;
  localparam int PIN_GATE1 = 3;

  typedef enum logic [1:0] {
    DMTC_MODE_13BIT = 2'b00,
    DMTC_MODE_16BIT = 2'b01,
    DMTC_MODE_RELOAD = 2'b10,
    DMTC_MODE_SPLIT = 2'b11
  } dmtc_mode_e;

  // bit order matches one nibble of the timer mode register
  typedef struct packed {
    logic gate_en;
    logic src_sel;
    dmtc_mode_e mode;
  } dmtc_chcfg_s;

endpackage

//--- hw/dmtc_channel.sv
// Purpose: one timer/counter channel with its high and low count bytes
// Assumes: tick and fall strobes are single-cycle and already qualified
// Notes: a software write to a count byte overrides counting in that cycle
`timescale 1ns/1ps
module dmtc_channel #(
  parameter bit HALT_IN_SPLIT = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire dmtc_pkg::dmtc_chcfg_s cfg_in,
  input wire logic run_in,
  input wire logic gate_pin_in,
  input wire logic tick_in,
  input wire logic fall_in,
  input wire logic high_run_in,
  input wire logic wr_low_in,
  input wire logic wr_high_in,
  input wire logic [dmtc_pkg::BYTE_W-1:0] wdata_in,
  output logic [dmtc_pkg::BYTE_W-1:0] low_out,
  output logic [dmtc_pkg::BYTE_W-1:0] high_out,
  output logic low_ovf_out,
  output logic high_ovf_out
);

  logic [dmtc_pkg::BYTE_W-1:0] low_reg;
  logic [dmtc_pkg::BYTE_W-1:0] low_next;
  logic [dmtc_pkg::BYTE_W-1:0] high_reg;
  logic [dmtc_pkg::BYTE_W-1:0] high_next;

  // RL2 source select
  wire logic count_src = cfg_in.src_sel ? fall_in : tick_in;
  // RL9 RL20 gate qualify
  wire logic gate_ok = !cfg_in.gate_en || gate_pin_in;
  wire logic step = run_in && gate_ok && count_src;
  // RL17 split high byte
  wire logic split_high_step = high_run_in && tick_in;
  wire logic prescale_wrap = (low_reg[dmtc_pkg::PRESCALE_W-1:0] == dmtc_pkg::PRESCALE_MAX);
  wire logic low_full = (low_reg == dmtc_pkg::BYTE_ONES);
  wire logic high_full = (high_reg == dmtc_pkg::BYTE_ONES);
  wire logic [dmtc_pkg::BYTE_W-1:0] low_inc = low_reg + dmtc_pkg::BYTE_ONE;
  wire logic [dmtc_pkg::BYTE_W-1:0] high_inc = high_reg + dmtc_pkg::BYTE_ONE;

  always_comb
  begin
    low_next = low_reg;
    high_next = high_reg;
    low_ovf_out = 1'b0;
    high_ovf_out = 1'b0;
    case (cfg_in.mode)
      // RL12 prescaler mode
      dmtc_pkg::DMTC_MODE_13BIT:
      begin
        if (step)
        begin
          low_next[dmtc_pkg::PRESCALE_W-1:0] =
            low_reg[dmtc_pkg::PRESCALE_W-1:0] + dmtc_pkg::PRESCALE_ONE;
          if (prescale_wrap)
          begin
            high_next = high_inc;
            // RL10 rollover flag
            low_ovf_out = high_full;
          end
        end
      end
      // RL13 cascade mode
      dmtc_pkg::DMTC_MODE_16BIT:
      begin
        if (step)
        begin
          low_next = low_inc;
          if (low_full)
          begin
            high_next = high_inc;
            low_ovf_out = high_full;
          end
        end
      end
      // RL14 RL15 auto reload
      dmtc_pkg::DMTC_MODE_RELOAD:
      begin
        if (step)
        begin
          low_next = low_full ? high_reg : low_inc;
          low_ovf_out = low_full;
        end
      end
      // RL16 RL18 split or halt
      dmtc_pkg::DMTC_MODE_SPLIT:
      begin
        if (!HALT_IN_SPLIT)
        begin
          if (step)
          begin
            low_next = low_inc;
            low_ovf_out = low_full;
          end
          if (split_high_step)
          begin
            high_next = high_inc;
            high_ovf_out = high_full;
          end
        end
      end
      default:
      begin
        low_next = low_reg;
      end
    endcase
    // RL6 preset writes
    if (wr_low_in)
    begin
      low_next = wdata_in;
    end
    if (wr_high_in)
    begin
      high_next = wdata_in;
    end
  end

  // RL5 run keeps count
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      low_reg <= dmtc_pkg::COUNT_RST;
      high_reg <= dmtc_pkg::COUNT_RST;
    end
    else
    begin
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  assign low_out = low_reg;
  assign high_out = high_reg;

endmodule

//--- dv/dmtc_pins_model.sv
// Purpose: pin-side partner driving count and gate inputs
// Assumes: count pins idle high as with a pull-up, gates idle low
// Notes: second-channel pins stay at idle levels
`timescale 1ns/1ps
module dmtc_pins_model (
  input wire logic clk_in,
  output logic count0_out,
  output logic count1_out,
  output logic first_gate_enable_out,
  output logic gate1_out
);
  initial
  begin
    count0_out = 1'b1;
    count1_out = 1'b1;
    first_gate_enable_out = 1'b0;
    gate1_out = 1'b0;
  end

  // each level held two cycles
  // slack covers the input synchroniser on top of one peripheral cycle
  task automatic fall_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      count0_out <= 1'b0;
      repeat (12) @(posedge clk_in);
      count0_out <= 1'b1;
      repeat (11) @(posedge clk_in);
    end
  endtask

  // high for exactly cyc edges so the count window is exact
  task automatic gate_window(input int cyc);
    @(posedge clk_in);
    first_gate_enable_out <= 1'b1;
    repeat (cyc) @(posedge clk_in);
    first_gate_enable_out <= 1'b0;
  endtask
endmodule

//--- dv/dmtc_assertions.sv
// Purpose: port-level checks of bus answers and overflow flags
// Assumes: zero wait state slave, flags visible on the irq outputs
// Notes: run bits are shadowed from control writes
`timescale 1ns/1ps
module dmtc_assertions (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [dmtc_pkg::APB_AW-1:0] PADDR_IN,
  input wire logic [dmtc_pkg::APB_DW-1:0] PWDATA_IN,
  input wire logic [dmtc_pkg::APB_DW-1:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic FIRST_IRQ_ACK_IN,
  input wire logic SECOND_IRQ_ACK_IN,
  input wire logic FIRST_IRQ_OUT,
  input wire logic SECOND_IRQ_OUT
);
  logic run0_reg;
  logic run1_reg;
  wire acc = PSEL_IN && PENABLE_IN;
  wire ctrl_hit = PADDR_IN == dmtc_pkg::OFF_CTRL;
  wire ctrl_wr = acc && PWRITE_IN && ctrl_hit;
  wire mapped = PADDR_IN[1:0] == 2'h0 && PADDR_IN <= dmtc_pkg::OFF_HIGH1;
  wire quiet = !run0_reg && !run1_reg;
  wire no_ack = !FIRST_IRQ_ACK_IN && !SECOND_IRQ_ACK_IN;

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      run0_reg <= 1'b0;
      run1_reg <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      run0_reg <= PWDATA_IN[dmtc_pkg::CTRL_RUN0_BIT];
      run1_reg <= PWDATA_IN[dmtc_pkg::CTRL_RUN1_BIT];
    end
  end

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_ctrl_setup;
    PSEL_IN && !PENABLE_IN && !PWRITE_IN && ctrl_hit;
  endsequence
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence

  a_ready_high: assert property (PREADY_OUT)
    else $error("ready dropped");
  a_upper_zero: assert property (PRDATA_OUT[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_err_unmapped: assert property (acc && !mapped |-> PSLVERR_OUT && (PWRITE_IN || PRDATA_OUT == 32'h0))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (PSEL_IN && (!PENABLE_IN || mapped) |-> !PSLVERR_OUT)
    else $error("spurious slave error");
  a_flag_readback: assert property (s_ctrl_setup ##1 s_access |-> PRDATA_OUT[5] == $past(FIRST_IRQ_OUT) && PRDATA_OUT[7] == $past(SECOND_IRQ_OUT))
    else $error("flag bits differ from irq");
  a_ack_clears: assert property (FIRST_IRQ_ACK_IN && quiet && !ctrl_wr |=> !FIRST_IRQ_OUT)
    else $error("ack left flag set");
  a_flags_quiet: assert property (quiet && !ctrl_wr && no_ack |=> $stable(FIRST_IRQ_OUT) && $stable(SECOND_IRQ_OUT))
    else $error("flag moved while stopped");
  a_wr_clears: assert property (ctrl_wr && quiet && !PWDATA_IN[5] |=> !FIRST_IRQ_OUT)
    else $error("flag write zero ignored");
  a_reset_idle: assert property ($fell(RESET_IN) |-> !FIRST_IRQ_OUT && !SECOND_IRQ_OUT && PRDATA_OUT == 32'h0)
    else $error("outputs not idle after reset");
endmodule

bind dmtc_top dmtc_assertions u_chk (
  .CLK_IN,
  .RESET_IN,
  .PSEL_IN,
  .PENABLE_IN,
  .PWRITE_IN,
  .PADDR_IN,
  .PWDATA_IN,
  .PRDATA_OUT,
  .PREADY_OUT,
  .PSLVERR_OUT,
  .FIRST_IRQ_ACK_IN,
  .SECOND_IRQ_ACK_IN,
  .FIRST_IRQ_OUT,
  .SECOND_IRQ_OUT
);

//--- dv/tb_top.sv
// Purpose: self-checking bench for the dual mode timer/counter
// Assumes: zero wait state bus, pins driven by the pin model
// Notes: count windows are made exact by gate pulses or run writes
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] MD = dmtc_pkg::OFF_MODE;
  localparam logic [7:0] CT = dmtc_pkg::OFF_CTRL;
  localparam logic [7:0] L0 = dmtc_pkg::OFF_LOW0;
  localparam logic [7:0] H0 = dmtc_pkg::OFF_HIGH0;
  localparam logic [7:0] L1 = dmtc_pkg::OFF_LOW1;
  logic clk, rst, psel, pen, pwr, ack0, ack1, pr, perr, serr, irq0, irq1;
  logic cp0, cp1, gp0, gp1;
  logic [7:0] addr;
  logic [31:0] wd, prd, rd;
  logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  int err_count, total_checks;

  dmtc_top u_dut (
    .CLK_IN(clk),
    .RESET_IN(rst),
    .PSEL_IN(psel),
    .PENABLE_IN(pen),
    .PWRITE_IN(pwr),
    .PADDR_IN(addr),
    .PWDATA_IN(wd),
    .PRDATA_OUT(prd),
    .PREADY_OUT(pr),
    .PSLVERR_OUT(perr),
    .FIRST_COUNT_PIN_IN(cp0),
    .SECOND_COUNT_PIN_IN(cp1),
    .FIRST_EXTERNAL_GATE_PIN_IN(gp0),
    .SECOND_EXTERNAL_GATE_PIN_IN(gp1),
    .FIRST_IRQ_ACK_IN(ack0),
    .SECOND_IRQ_ACK_IN(ack1),
    .FIRST_IRQ_OUT(irq0),
    .SECOND_IRQ_OUT(irq1)
  );

  dmtc_pins_model u_pins (
    .clk_in(clk),
    .count0_out(cp0),
    .count1_out(cp1),
    .first_gate_enable_out(gp0),
    .gate1_out(gp1)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pr !== 1'b1) @(posedge clk);
    rd = prd;
    serr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // gate open for k peripheral cycles, then let the synchroniser drain
  task automatic gwin(input int k);
    u_pins.gate_window(6 * k);
    idle(8);
  endtask

  initial
  begin
    repeat (6000) @(posedge clk);
    err_count++;
    final_report();
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    addr = 8'h00;
    wd = 32'h0;
    ack0 = 1'b0;
    ack1 = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) rdc(offs[i], 32'h0);
    rdc(8'h18, 32'h0);
    check({31'h0, serr}, 32'h1);
    wr(MD, 32'h01);
    rdc(MD, 32'h01);
    wr(CT, 32'h10);
    idle(21);
    wr(CT, 32'h00);
    rdc(L0, 32'h04);
    wr(MD, 32'h05);
    wr(L0, 32'h00);
    wr(CT, 32'h10);
    u_pins.fall_pulses(3);
    idle(20);
    wr(CT, 32'h00);
    rdc(L0, 32'h03);
    wr(MD, 32'h09);
    wr(L0, 32'hFF);
    wr(H0, 32'hFF);
    wr(CT, 32'h10);
    idle(30);
    rdc(L0, 32'hFF);
    gwin(1);
    check({31'h0, irq0}, 32'h1);
    rdc(L0, 32'h00);
    rdc(H0, 32'h00);
    rdc(CT, 32'h30);
    wr(CT, 32'h20);
    wr(CT, 32'h00);
    idle(1);
    check({31'h0, irq0}, 32'h0);
    wr(MD, 32'h08);
    wr(L0, 32'h1F);
    wr(H0, 32'h05);
    wr(CT, 32'h10);
    gwin(1);
    wr(CT, 32'h00);
    rdc(H0, 32'h06);
    rdc(L0, 32'h00);
    wr(MD, 32'h0A);
    wr(L0, 32'hFE);
    wr(H0, 32'h80);
    wr(CT, 32'h10);
    gwin(3);
    rdc(L0, 32'h81);
    rdc(H0, 32'h80);
    wr(H0, 32'hC0);
    // clear the earlier reload flag so the long run must set it again
    ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    idle(1);
    check({31'h0, irq0}, 32'h0);
    gwin(127);
    rdc(L0, 32'hC0);
    check({31'h0, irq0}, 32'h1);
    wr(CT, 32'h20);
    ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    idle(1);
    check({31'h0, irq0}, 32'h0);
    wr(CT, 32'h00);
    wr(MD, 32'h3B);
    rdc(MD, 32'h3B);
    wr(L0, 32'h10);
    wr(H0, 32'hFF);
    wr(L1, 32'h50);
    wr(CT, 32'h50);
    idle(9);
    // keep flag1 set while run1 stops
    wr(CT, 32'h90);
    gwin(3);
    check({31'h0, irq1}, 32'h1);
    ack1 <= 1'b1;
    @(posedge clk);
    ack1 <= 1'b0;
    idle(1);
    check({31'h0, irq1}, 32'h0);
    wr(CT, 32'h00);
    rdc(H0, 32'h01);
    rdc(L0, 32'h13);
    rdc(L1, 32'h50);
    final_report();
  end
endmodule
